// *** core/readout_pkg.sv ***
// Shared constants, types and helpers for the readout trigger controller
package readout_pkg;
   localparam int NCH = 4;
   localparam int SMP_W = 12;
   localparam int WORD_W = 16;
   localparam int BUNCH_W = 12;
   localparam int EVENT_W = 8;
   localparam int DFIFO_DEPTH = 1024;
   localparam int DPTR_W = 10;
   localparam int TFIFO_DEPTH = 64;
   localparam int TPTR_W = 6;
   localparam int TREC_W = 1 + EVENT_W + BUNCH_W;
   localparam int EVCNT_W = 5;
   localparam int SYNC_W = NCH * SMP_W + 3 * NCH + 1;
   localparam logic [2:0] CMD_L1A = 3'h4;
   localparam logic [2:0] CMD_BZERO = 3'h5;
   localparam logic [2:0] CMD_FRONT_END_A = 3'h6;
   localparam logic [2:0] CMD_CAL = 3'h7;
   localparam logic [7:0] CAL_LATENCY_CYC = 8'h40;
   localparam logic [BUNCH_W-1:0] BUNCH_RESET = 12'h000;
   localparam logic [EVENT_W-1:0] EVENT_RESET = 8'h00;
   localparam logic [WORD_W-1:0] SOF_WORD = 16'hfc3c;
   localparam logic [WORD_W-1:0] EOF_WORD = 16'hfcbc;
   localparam logic [WORD_W-1:0] IDLE_WORD = 16'hbc50;
   // Arbitrary chip identifier value
   localparam logic [WORD_W-1:0] CHIP_ID = 16'h0a5a;
   localparam logic [WORD_W-1:0] CRC_POLY = 16'h1021;
   localparam logic [WORD_W-1:0] CRC_INIT = 16'hffff;

   typedef enum logic [1:0] {
      DEC_IDLE = 2'b00,
      DEC_BIT1 = 2'b01,
      DEC_BIT2 = 2'b10
   } dec_state_e;

   typedef enum logic [3:0] {
      F_IDLE = 4'b0000,
      F_SOF = 4'b0001,
      F_HDR1 = 4'b0010,
      F_HDR2 = 4'b0011,
      F_KID = 4'b0100,
      F_PAY = 4'b0101,
      F_FLUSH = 4'b0110,
      F_CRC = 4'b0111,
      F_EOF = 4'b1000
   } fmt_state_e;

   function automatic logic [WORD_W-1:0] crc16_step(input logic [WORD_W-1:0] crc,
                                                    input logic [WORD_W-1:0] word);
      logic [WORD_W-1:0] c;
      c = crc;
      for (int i = WORD_W - 1; i >= 0; i--)
      begin
         c = (c[WORD_W-1] ^ word[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc16_step
endpackage : readout_pkg

// *** core/readout_ifs.sv ***
// Carriers between the controller and its decoder and checksum engine
`timescale 1ns/1ns
interface trig_cmd_if;
   logic valid;
   logic [2:0] code;
   modport src (output valid, output code);
   modport dst (input valid, input code);
endinterface : trig_cmd_if

interface crc_if;
   logic clear;
   logic en;
   logic [15:0] word;
   logic [15:0] value;
   modport eng (input clear, input en, input word, output value);
   modport user (output clear, output en, output word, input value);
endinterface : crc_if

// *** core/trig_decoder.sv ***
// Serial trigger command decoder
`timescale 1ns/1ns
module trig_decoder
   import readout_pkg::*;
(
   input wire logic ref_clk_i, // system clock
   input wire logic rst_i, // synchronous reset
   input wire logic line_i, // synchronised serial trigger line
   trig_cmd_if.src cmd // decoded command pulse
);
   dec_state_e state;
   logic first_bit;

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state <= DEC_IDLE;
         first_bit <= 1'b0;
         cmd.valid <= 1'b0;
         cmd.code <= 3'h0;
      end
      else
      begin
         cmd.valid <= 1'b0;
         case (state)
            DEC_IDLE: if (line_i) state <= DEC_BIT1;
            DEC_BIT1:
            begin
               first_bit <= line_i;
               state <= DEC_BIT2;
            end
            DEC_BIT2:
            begin
               cmd.valid <= 1'b1;
               cmd.code <= {1'b1, first_bit, line_i};
               state <= DEC_IDLE;
            end
            default: state <= DEC_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   property p_group;
      cmd.valid |-> cmd.code == {$past(line_i, 3), $past(line_i, 2), $past(line_i, 1)};
   endproperty
   a_group: assert property (p_group) else $error("command not from three bits");
   property p_spacing;
      cmd.valid |=> !cmd.valid ##1 !cmd.valid;
   endproperty
   a_spacing: assert property (p_spacing) else $error("commands overlap");
endmodule : trig_decoder

// *** core/crc16_engine.sv ***
// Running CRC-16 over the packet words
`timescale 1ns/1ns
module crc16_engine
   import readout_pkg::*;
(
   input wire logic ref_clk_i, // system clock
   input wire logic rst_i, // synchronous reset
   crc_if.eng c // clear, update and result
);
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || c.clear)
         c.value <= CRC_INIT;
      else if (c.en)
         c.value <= crc16_step(c.value, c.word);
   end
endmodule : crc16_engine

// *** core/readout_trigger_control.sv ***
// Readout trigger controller: command decode, counters, buffers, supervisor, packetiser
// Operation
// - Commands are three consecutive trigger line bits
// - 100 is trigger accept, 101 bunch zero
// - 110 is resynchronise, 111 is calibration
// - Accept: pulse, count event, queue normal record
// - Calibration: pulse and start latency down-count
// - Latency expiry: count event, queue calibration record
// - Front_end_a clears counters and all buffers
// - Front_end_a clears every supervisor error flag
// - Bunch zero clears counters, buffers untouched
// - Bunch counter is 12 bits, counts every clock
// - Event counter is 8 bits, counts triggers
// - Pop pending record into packet header
// - Then forward data of all active channels
// - Append CRC to every packet
// - Pack 12-bit samples into 16-bit words
// - Drive clock, trigger, front_end_a, calibration pulses
// - Watch frame valid, column, almost full
// - Flag out-of-sync and almost-full separately
// - One-way link without back-pressure
// - Normal mode and link test mode
// - Host may write pseudo-event data
`timescale 1ns/1ns
module readout_trigger_control
   import readout_pkg::*;
(
   input wire logic ref_clk_i, // system clock
   input wire logic rst_i, // synchronous reset, active high
   input wire logic trigger_serial_line_i, // serial trigger commands
   input wire logic link_test_mode_i, // 1: link test mode
   input wire logic [NCH-1:0] chan_mask_i, // active channels
   input wire logic [NCH*SMP_W-1:0] adc_sample_i, // samples, channel 0 lowest
   input wire logic [NCH-1:0] readout_frame_valid_i, // front-end frame valid
   input wire logic [NCH-1:0] col_addr_serial_i, // front-end column address bit
   input wire logic [NCH-1:0] fe_almost_full_i, // front-end trigger buffer almost full
   input wire logic test_wr_i, // host pseudo-event write strobe
   input wire logic [1:0] test_chan_i, // host write channel
   input wire logic [SMP_W-1:0] test_data_i, // host write sample
   input wire logic test_last_i, // host write ends the event
   output logic fe_clk_o, // front-end clock
   output logic front_end_trigger_pulse_o, // trigger pulse
   output logic front_end_a_o, // resynchronisation pulse
   output logic calibration_pulse_o, // calibration pulse
   output logic [WORD_W-1:0] link_data_o, // link word
   output logic link_valid_o, // link word is packet data
   output logic [BUNCH_W-1:0] bunch_crossing_counter_o, // bunch counter
   output logic [EVENT_W-1:0] event_counter_o, // event counter
   output logic [NCH-1:0] out_of_sync_o, // sticky out-of-sync per channel
   output logic almost_full_err_o, // sticky almost-full error
   output logic [NCH-1:0] fifo_full_o // data buffer full per channel
);
   // Front-end and trigger line pins pass two flops before anything reads them
   logic [SYNC_W-1:0] sync1, sync2;
   wire [SMP_W*NCH-1:0] smp_s = sync2[SYNC_W-1:3*NCH+1];
   wire [NCH-1:0] fv_s = sync2[3*NCH:2*NCH+1];
   wire [NCH-1:0] col_s = sync2[2*NCH:NCH+1];
   wire [NCH-1:0] af_s = sync2[NCH:1];
   wire line_s = sync2[0];

   always_ff @(posedge ref_clk_i)
   begin
      sync1 <= rst_i ? '0 : {adc_sample_i, readout_frame_valid_i, col_addr_serial_i,
                             fe_almost_full_i, trigger_serial_line_i};
      sync2 <= rst_i ? '0 : sync1;
   end

   trig_cmd_if cmd ();
   trig_decoder u_dec (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .line_i(line_s), .cmd(cmd));

   wire is_l1a = cmd.valid && cmd.code == CMD_L1A;
   wire is_bzero = cmd.valid && cmd.code == CMD_BZERO;
   wire is_front_end_a = cmd.valid && cmd.code == CMD_FRONT_END_A;
   wire is_cal = cmd.valid && cmd.code == CMD_CAL;
   wire clr_cnt = is_front_end_a || is_bzero;

   // Calibration latency; a coincident accept defers expiry by one cycle
   logic [7:0] cal_cnt;
   wire cal_expire = cal_cnt == 8'h01 && !is_l1a;
   wire count_ev = is_l1a || cal_expire;

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || is_front_end_a)
         cal_cnt <= 8'h00;
      else if (is_cal)
         cal_cnt <= CAL_LATENCY_CYC;
      else if (cal_cnt != 8'h00 && !(cal_cnt == 8'h01 && is_l1a))
         cal_cnt <= cal_cnt - 8'h01;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || clr_cnt)
      begin
         bunch_crossing_counter_o <= BUNCH_RESET;
         event_counter_o <= EVENT_RESET;
      end
      else
      begin
         bunch_crossing_counter_o <= bunch_crossing_counter_o + 12'h001;
         if (count_ev)
            event_counter_o <= event_counter_o + 8'h01;
      end
   end

   // Front-end clock is the system clock halved, from a flop
   always_ff @(posedge ref_clk_i)
   begin
      fe_clk_o <= rst_i ? 1'b0 : !fe_clk_o;
      front_end_trigger_pulse_o <= !rst_i && is_l1a;
      front_end_a_o <= !rst_i && is_front_end_a;
      calibration_pulse_o <= !rst_i && is_cal;
   end

   // Trigger record buffer
   logic [TREC_W-1:0] tmem [TFIFO_DEPTH];
   logic [TPTR_W:0] twp, trp;
   logic pop_trig;
   wire [TPTR_W:0] tcount = twp - trp;
   wire t_empty = tcount == '0;
   wire t_full = tcount == (TPTR_W + 1)'(TFIFO_DEPTH);
   wire [TREC_W-1:0] t_head = tmem[trp[TPTR_W-1:0]];

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || is_front_end_a)
      begin
         twp <= '0;
         trp <= '0;
      end
      else
      begin
         if (count_ev && !t_full)
         begin
            tmem[twp[TPTR_W-1:0]] <= {cal_expire, event_counter_o + 8'h01,
                                      bunch_crossing_counter_o};
            twp <= twp + 1'b1;
         end
         if (pop_trig)
            trp <= trp + 1'b1;
      end
   end

   // Channel data buffers; top bit marks the last sample of an event
   logic [SMP_W:0] dmem [NCH][DFIFO_DEPTH];
   logic [DPTR_W:0] wptr [NCH];
   logic [DPTR_W:0] rptr [NCH];
   logic [EVCNT_W-1:0] evcnt [NCH];
   logic [NCH-1:0] fv_d;
   logic [SMP_W*NCH-1:0] smp_d;
   logic [1:0] ch;
   logic rd_go;
   wire [NCH-1:0] wr_en, rd_en, full, ev_ok, wr_last, rd_last;
   wire [SMP_W:0] wr_data [NCH];
   wire [SMP_W:0] head = dmem[ch][rptr[ch][DPTR_W-1:0]];

   for (genvar c = 0; c < NCH; c++)
   begin : g_chan
      assign full[c] = (wptr[c] - rptr[c]) == (DPTR_W + 1)'(DFIFO_DEPTH);
      assign wr_en[c] = (link_test_mode_i ? (test_wr_i && test_chan_i == 2'(c))
                        : (chan_mask_i[c] && fv_d[c])) && !full[c];
      assign wr_data[c] = link_test_mode_i ? {test_last_i, test_data_i}
                          : {!fv_s[c], smp_d[c*SMP_W +: SMP_W]};
      assign wr_last[c] = wr_en[c] && wr_data[c][SMP_W];
      assign rd_en[c] = rd_go && ch == 2'(c);
      assign rd_last[c] = rd_en[c] && head[SMP_W];
      assign ev_ok[c] = !chan_mask_i[c] || evcnt[c] != '0;
   end

   always_ff @(posedge ref_clk_i)
   begin
      fv_d <= rst_i ? '0 : fv_s;
      smp_d <= rst_i ? '0 : smp_s;
      for (int c = 0; c < NCH; c++)
      begin
         if (wr_en[c])
            dmem[c][wptr[c][DPTR_W-1:0]] <= wr_data[c];
         if (rst_i || is_front_end_a)
         begin
            wptr[c] <= '0;
            rptr[c] <= '0;
            evcnt[c] <= '0;
         end
         else
         begin
            if (wr_en[c])
               wptr[c] <= wptr[c] + 1'b1;
            if (rd_en[c])
               rptr[c] <= rptr[c] + 1'b1;
            if (wr_last[c] && !rd_last[c])
               evcnt[c] <= evcnt[c] + 1'b1;
            else if (rd_last[c] && !wr_last[c])
               evcnt[c] <= evcnt[c] - 1'b1;
         end
      end
      fifo_full_o <= rst_i ? '0 : full;
   end

   // Supervisor: lowest active channel is the reference sequence
   logic [6:0] rd_pend;
   logic ref_fv, ref_col, ref_fv_d;
   always_comb
   begin
      ref_fv = 1'b0;
      ref_col = 1'b0;
      for (int c = NCH - 1; c >= 0; c--)
      begin
         if (chan_mask_i[c])
         begin
            ref_fv = fv_s[c];
            ref_col = col_s[c];
         end
      end
   end
   wire ref_rise = ref_fv && !ref_fv_d;
   wire [NCH-1:0] mismatch = chan_mask_i & ((fv_s ^ {NCH{ref_fv}}) | (col_s ^ {NCH{ref_col}}));
   wire [NCH-1:0] unexpected = (ref_rise && rd_pend == 7'h00) ? chan_mask_i : '0;
   wire af_now = |(chan_mask_i & af_s);

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         out_of_sync_o <= '0;
         almost_full_err_o <= 1'b0;
         rd_pend <= 7'h00;
         ref_fv_d <= 1'b0;
      end
      else
      begin
         // A new error in the clearing cycle still sets the flag
         out_of_sync_o <= (is_front_end_a ? '0 : out_of_sync_o) | mismatch | unexpected;
         almost_full_err_o <= (!is_front_end_a && almost_full_err_o) || af_now;
         ref_fv_d <= ref_fv;
         if (is_front_end_a)
            rd_pend <= 7'h00;
         else if (is_l1a && !(ref_rise && rd_pend != 7'h00))
            rd_pend <= rd_pend + 7'h01;
         else if (!is_l1a && ref_rise && rd_pend != 7'h00)
            rd_pend <= rd_pend - 7'h01;
      end
   end

   // Packetiser
   fmt_state_e fstate, next_fstate;
   logic [1:0] next_ch;
   logic [TREC_W-1:0] hdr;
   logic hdr_test;
   logic [27:0] acc;
   logic [4:0] nb;
   logic emit;
   logic [WORD_W-1:0] word;
   crc_if crc ();
   crc16_engine u_crc (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .c(crc));

   wire all_ready = &ev_ok;
   wire any_data = |chan_mask_i;
   wire start = link_test_mode_i ? (all_ready && any_data) : (!t_empty && all_ready);
   wire [27:0] pk_sum = acc | (28'(head[SMP_W-1:0]) << nb);
   wire [4:0] pk_nbs = nb + 5'd12;
   wire pk_emit = pk_nbs >= 5'd16;
   wire oos_any = |out_of_sync_o;
   wire [3:0] flags1 = {hdr_test, hdr[TREC_W-1], oos_any, almost_full_err_o};
   wire [7:0] flags2 = {4'h0, oos_any ? out_of_sync_o : chan_mask_i};

   always_comb
   begin
      next_fstate = fstate;
      next_ch = ch;
      pop_trig = 1'b0;
      rd_go = 1'b0;
      emit = 1'b0;
      word = IDLE_WORD;
      case (fstate)
         F_IDLE:
            if (start)
            begin
               next_fstate = F_SOF;
               pop_trig = !link_test_mode_i;
            end
         F_SOF:
         begin
            emit = 1'b1;
            word = SOF_WORD;
            next_fstate = F_HDR1;
         end
         F_HDR1:
         begin
            emit = 1'b1;
            word = {flags1, hdr[BUNCH_W-1:0]};
            next_fstate = F_HDR2;
         end
         F_HDR2:
         begin
            emit = 1'b1;
            word = {flags2, hdr[BUNCH_W +: EVENT_W]};
            next_fstate = F_KID;
         end
         F_KID:
         begin
            emit = 1'b1;
            word = CHIP_ID;
            next_ch = 2'd0;
            next_fstate = F_PAY;
         end
         F_PAY:
         begin
            rd_go = chan_mask_i[ch];
            emit = rd_go && pk_emit;
            word = pk_sum[WORD_W-1:0];
            if (!chan_mask_i[ch] || head[SMP_W])
            begin
               if (ch == 2'd3)
                  next_fstate = F_FLUSH;
               else
                  next_ch = ch + 2'd1;
            end
         end
         F_FLUSH:
         begin
            emit = nb != 5'd0;
            word = acc[WORD_W-1:0];
            next_fstate = F_CRC;
         end
         F_CRC:
         begin
            emit = 1'b1;
            word = crc.value;
            next_fstate = F_EOF;
         end
         F_EOF:
         begin
            emit = 1'b1;
            word = EOF_WORD;
            next_fstate = F_IDLE;
         end
         default: next_fstate = F_IDLE;
      endcase
   end

   assign crc.clear = fstate == F_SOF;
   assign crc.en = emit && fstate != F_SOF && fstate != F_CRC && fstate != F_EOF;
   assign crc.word = word;

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || is_front_end_a)
      begin
         fstate <= F_IDLE;
         ch <= 2'd0;
         link_valid_o <= 1'b0;
         link_data_o <= IDLE_WORD;
      end
      else
      begin
         fstate <= next_fstate;
         ch <= next_ch;
         // No ready from the far end: words go out as produced
         link_valid_o <= emit;
         link_data_o <= emit ? word : IDLE_WORD;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         hdr <= '0;
         hdr_test <= 1'b0;
      end
      else if (fstate == F_IDLE && start)
      begin
         hdr <= link_test_mode_i ? {1'b0, event_counter_o, bunch_crossing_counter_o} : t_head;
         hdr_test <= link_test_mode_i;
      end
      if (rst_i || fstate == F_SOF || fstate == F_FLUSH)
      begin
         acc <= 28'h000_0000;
         nb <= 5'd0;
      end
      else if (rd_go)
      begin
         acc <= pk_emit ? (pk_sum >> 16) : pk_sum;
         nb <= pk_emit ? pk_nbs - 5'd16 : pk_nbs;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   property p_l1a_pulse;
      is_l1a |=> front_end_trigger_pulse_o && !calibration_pulse_o;
   endproperty
   a_l1a_pulse: assert property (p_l1a_pulse) else $error("no trigger pulse");
   property p_ec_inc;
      (is_l1a && !clr_cnt) |=> event_counter_o == $past(event_counter_o) + 8'h01;
   endproperty
   a_ec_inc: assert property (p_ec_inc) else $error("event count not advanced");
   property p_bc_run;
      !clr_cnt |=> bunch_crossing_counter_o == $past(bunch_crossing_counter_o) + 12'h001;
   endproperty
   a_bc_run: assert property (p_bc_run) else $error("bunch counter stalled");
   property p_bzero;
      is_bzero |=> bunch_crossing_counter_o == 12'h000 && event_counter_o == 8'h00
                   && twp == $past(twp) + (TPTR_W + 1)'($past(count_ev) && !$past(t_full));
   endproperty
   a_bzero: assert property (p_bzero) else $error("bunch zero mishandled");
   property p_front_end_a;
      is_front_end_a |=> t_empty && wptr[0] == '0 && rptr[3] == '0 && fstate == F_IDLE;
   endproperty
   a_front_end_a: assert property (p_front_end_a) else $error("front_end_a left buffers");
   property p_front_end_a_err;
      (is_front_end_a && mismatch == '0 && unexpected == '0) |=> out_of_sync_o == '0;
   endproperty
   a_front_end_a_err: assert property (p_front_end_a_err) else $error("error flags kept");
   property p_cal;
      is_cal |=> calibration_pulse_o && cal_cnt == CAL_LATENCY_CYC;
   endproperty
   a_cal: assert property (p_cal) else $error("calibration not started");
   property p_cal_rec;
      (cal_expire && !t_full && !is_front_end_a) |=> tmem[$past(twp[TPTR_W-1:0])][TREC_W-1];
   endproperty
   a_cal_rec: assert property (p_cal_rec) else $error("calibration record missing");
   property p_crc_out;
      fstate == F_CRC && !is_front_end_a |=> link_valid_o && link_data_o == $past(crc.value);
   endproperty
   a_crc_out: assert property (p_crc_out) else $error("crc word wrong");
   property p_start_ready;
      (fstate == F_IDLE && next_fstate == F_SOF) |->
         (chan_mask_i & {wptr[3] != rptr[3], wptr[2] != rptr[2], wptr[1] != rptr[1],
                         wptr[0] != rptr[0]}) == chan_mask_i;
   endproperty
   a_start_ready: assert property (p_start_ready) else $error("started without data");
   property p_pack;
      nb < 5'd16;
   endproperty
   a_pack: assert property (p_pack) else $error("packer overrun");
endmodule : readout_trigger_control

// *** tb/trig_source.sv ***
// Serial trigger command source model
`timescale 1ns/1ns
module trig_source
(
   input wire logic ref_clk_i, // system clock
   output logic line_o // serial trigger line
);
   initial line_o = 1'b0;
   // Leading one, then two code bits, one per clock
   task automatic send(input logic [1:0] code);
      @(negedge ref_clk_i) line_o = 1'b1;
      @(negedge ref_clk_i) line_o = code[1];
      @(negedge ref_clk_i) line_o = code[0];
      @(negedge ref_clk_i) line_o = 1'b0;
   endtask : send
endmodule : trig_source

// *** tb/readout_trigger_control_tb.sv ***
// Self-checking bench for the readout trigger controller
`timescale 1ns/1ns
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
   $display("MISMATCH %0t %s", $time, m); end end
module readout_trigger_control_tb
   import readout_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, tmode = 1'b0, twr = 1'b0, tlast = 1'b0;
   logic [3:0] mask = 4'h0, fv = 4'h0, col = 4'h0, af = 4'h0;
   logic [47:0] adc = 48'h0;
   logic [1:0] tch = 2'h0;
   logic [11:0] tdat = 12'h0;
   logic line, fck, tp, rs, cp, lval, aferr;
   logic [15:0] ld, c;
   logic [11:0] bunch, b0;
   logic [7:0] evt;
   logic [3:0] oos, ffull;
   logic [15:0] q[$];
   int error_cnt = 0, n_tests = 0;
   initial forever #5 clk = ~clk;
   trig_source src_u (.ref_clk_i(clk), .line_o(line));
   readout_trigger_control dut_u (.ref_clk_i(clk), .rst_i(rst), .trigger_serial_line_i(line),
      .link_test_mode_i(tmode), .chan_mask_i(mask), .adc_sample_i(adc),
      .readout_frame_valid_i(fv), .col_addr_serial_i(col), .fe_almost_full_i(af),
      .test_wr_i(twr), .test_chan_i(tch), .test_data_i(tdat), .test_last_i(tlast),
      .fe_clk_o(fck), .front_end_trigger_pulse_o(tp), .front_end_a_o(rs),
      .calibration_pulse_o(cp), .link_data_o(ld), .link_valid_o(lval),
      .bunch_crossing_counter_o(bunch), .event_counter_o(evt), .out_of_sync_o(oos),
      .almost_full_err_o(aferr), .fifo_full_o(ffull));
   task automatic give_verdict;
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   function automatic logic sel(input int k);
      return (k == 0) ? tp : (k == 1) ? rs : cp;
   endfunction : sel
   // Bounded wait for a pulse, sampled at the falling edge
   task automatic wait_hi(input int k);
      int i;
      i = 0;
      while (sel(k) !== 1'b1)
      begin
         @(negedge clk);
         i++;
         if (i > 12)
         begin
            `CHK(1'b0, 1'b1, "pulse missing")
            give_verdict();
         end
      end
   endtask : wait_hi
   task automatic s_reset;
      repeat (20) @(negedge clk);
      `CHK(ld, IDLE_WORD, "idle word")
      `CHK(bunch, 12'h000, "bunch count in reset")
      rst = 1'b0;
      repeat (2) @(negedge clk);
      b0[0] = fck;
      @(negedge clk);
      `CHK(fck, ~b0[0], "fe clock")
   endtask : s_reset
   task automatic s_accept;
      src_u.send(2'b00);
      wait_hi(0);
      `CHK(evt, 8'h01, "event count")
      @(negedge clk);
      `CHK(tp, 1'b0, "pulse width")
      b0 = bunch;
      repeat (10) @(negedge clk);
      `CHK(bunch, b0 + 12'h00a, "bunch count rate")
   endtask : s_accept
   task automatic s_bzero;
      src_u.send(2'b01);
      repeat (6) @(negedge clk);
      `CHK(evt, 8'h00, "bunch zero event count")
      `CHK(bunch < 12'h010, 1'b1, "bunch zero bunch count")
   endtask : s_bzero
   task automatic s_cal;
      src_u.send(2'b11);
      wait_hi(2);
      `CHK(evt, 8'h00, "cal early")
      repeat (50) @(negedge clk);
      `CHK(evt, 8'h00, "cal latency")
      repeat (20) @(negedge clk);
      `CHK(evt, 8'h01, "cal expiry")
   endtask : s_cal
   // Channel 1 stays silent while channel 0 frames: a step mismatch
   task automatic s_err_front_end_a;
      // Empty packet of the calibration record must end before the mask moves
      repeat (10) @(negedge clk);
      mask = 4'h3;
      af = 4'h1;
      fv = 4'h1;
      repeat (4) @(negedge clk);
      fv = 4'h0;
      af = 4'h0;
      repeat (6) @(negedge clk);
      `CHK(oos[1], 1'b1, "oos flag")
      `CHK(aferr, 1'b1, "almost full")
      src_u.send(2'b10);
      wait_hi(1);
      repeat (3) @(negedge clk);
      `CHK(evt, 8'h00, "front_end_a event count")
      `CHK(bunch < 12'h010, 1'b1, "front_end_a bunch count")
      `CHK({oos, aferr}, 5'h00, "front_end_a flags")
      `CHK(ffull, 4'h0, "buffers free")
   endtask : s_err_front_end_a
   task automatic s_link;
      @(negedge clk);
      tmode = 1'b1;
      mask = 4'h1;
      twr = 1'b1;
      tdat = 12'habc;
      tlast = 1'b1;
      @(negedge clk);
      twr = 1'b0;
      tlast = 1'b0;
      repeat (60)
      begin
         @(negedge clk);
         if (lval === 1'b1)
            q.push_back(ld);
      end
      c = CRC_INIT;
      for (int j = 1; j < 5; j++)
         for (int i = 15; i >= 0; i--)
            c = (c[15] ^ q[j][i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
      `CHK(q.size(), 7, "length")
      `CHK(q[0], SOF_WORD, "start")
      `CHK(q[1][15:12], 4'h8, "flags")
      `CHK(q[2], 16'h0100, "mask and ec")
      `CHK(q[3], CHIP_ID, "chip id")
      `CHK(q[4], 16'h0abc, "payload")
      `CHK(q[5], c, "crc")
      `CHK(q[6], EOF_WORD, "end")
      `CHK(ld, IDLE_WORD, "idle after")
   endtask : s_link
   initial
   begin
      s_reset();
      s_accept();
      s_bzero();
      s_cal();
      s_err_front_end_a();
      s_link();
      give_verdict();
   end
endmodule : readout_trigger_control_tb
